// ===== hw/mat_pkg.sv
package mat_pkg;

  // ---------------------------------------------------------------
  // special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SFR_MAIN_RESULT = 8'hE0;
  localparam logic [7:0] SFR_OPERAND_B   = 8'hF0;
  localparam logic [7:0] SFR_STATUS      = 8'hD0;
  localparam logic [7:0] SFR_PTR_LO      = 8'h82;
  localparam logic [7:0] SFR_PTR_HI      = 8'h83;

  // ---------------------------------------------------------------
  // status flags word bit positions
  // ---------------------------------------------------------------
  localparam int FLAG_CY = 7;
  localparam int FLAG_AC = 6;
  localparam int FLAG_OV = 2;
  localparam int BANK_LO = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PTR  = 16'h0000;
  localparam logic [15:0] RST_PC   = 16'h0000;

  // ---------------------------------------------------------------
  // cycle and byte counts
  // ---------------------------------------------------------------
  localparam logic [2:0] CYC_SHORT    = 3'h1;
  localparam logic [2:0] CYC_MEM_OPND = 3'h2;
  localparam logic [2:0] CYC_INC_REG  = 3'h2;
  localparam logic [2:0] CYC_RMW      = 3'h3;
  localparam logic [2:0] CYC_RMW_IMM  = 3'h4;
  localparam logic [2:0] CYC_MULDIV   = 3'h5;
  localparam logic [1:0] BYTES_ONE    = 2'h1;
  localparam logic [1:0] BYTES_TWO    = 2'h2;
  localparam logic [1:0] BYTES_THREE  = 2'h3;

  // ---------------------------------------------------------------
  // opcode encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_NOP  = 8'h00;
  localparam logic [7:0] OPC_MUL  = 8'hA4;
  localparam logic [7:0] OPC_DIV  = 8'h84;
  localparam logic [7:0] OPC_PINC = 8'hA3;
  localparam logic [7:0] OPC_CLR  = 8'hE4;
  localparam logic [7:0] OPC_CPL  = 8'hF4;
  localparam logic [7:0] OPC_RL   = 8'h23;
  localparam logic [7:0] OPC_RLC  = 8'h33;
  localparam logic [7:0] OPC_RR   = 8'h03;
  localparam logic [7:0] OPC_RRC  = 8'h13;
  localparam logic [7:0] OPC_SWAP = 8'hC4;
  localparam logic [7:0] OPC_DA   = 8'hD4;
  localparam logic [3:0] GRP_INC  = 4'h0;
  localparam logic [3:0] GRP_DEC  = 4'h1;
  localparam logic [3:0] GRP_ADD  = 4'h2;
  localparam logic [3:0] GRP_ADDC = 4'h3;
  localparam logic [3:0] GRP_ORL  = 4'h4;
  localparam logic [3:0] GRP_ANL  = 4'h5;
  localparam logic [3:0] GRP_XRL  = 4'h6;
  localparam logic [3:0] GRP_SUBB = 4'h9;
  localparam logic [3:0] LO_MEM_A   = 4'h2;
  localparam logic [3:0] LO_MEM_IMM = 4'h3;
  localparam logic [3:0] LO_IMM     = 4'h4;
  localparam logic [3:0] LO_DIR     = 4'h5;

  // ---------------------------------------------------------------
  // decimal adjust constants
  // ---------------------------------------------------------------
  localparam logic [3:0] BCD_MAX   = 4'h9;
  localparam logic [8:0] DA_LO_ADJ = 9'h006;
  localparam logic [8:0] DA_HI_ADJ = 9'h060;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_PASS, OP_ADD, OP_ADDC, OP_SUBB, OP_AND, OP_OR, OP_XOR,
    OP_INC, OP_DEC, OP_CLR, OP_CPL, OP_RL, OP_RLC, OP_RR, OP_RRC,
    OP_SWAP, OP_DA, OP_MUL, OP_DIV
  } mat_op_t;

  typedef enum logic [2:0] {
    K_NONE, K_NOP, K_ACC, K_UNARY, K_MEM, K_MULDIV, K_PTRINC
  } mat_kind_t;

  typedef enum logic [2:0] {M_NONE, M_REG, M_IND, M_DIR, M_IMM} mat_mode_t;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_A, SEL_B, SEL_PSW, SEL_PLO, SEL_PHI
  } mat_sfr_t;

  typedef struct packed {
    mat_kind_t  kind;
    mat_mode_t  mode;
    mat_op_t    aop;
    logic       mem_imm;
    logic [1:0] nbytes;
    logic [2:0] ncyc;
  } mat_dec_t;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] res_hi;
    logic       cy;
    logic       ac;
    logic       ov;
    logic       wr_cy;
    logic       wr_ac;
    logic       wr_ov;
    logic       wr_hi;
  } mat_alu_res_t;

endpackage

// ===== hw/mat_alu.sv
`timescale 1ns/1ps

module mat_alu (
  // operation and operands
  input  mat_pkg::mat_op_t     op,
  input  logic [7:0]           x,
  input  logic [7:0]           y,
  input  logic                 cy_in,
  input  logic                 ac_in,
  // result and flags
  output mat_pkg::mat_alu_res_t r
);

  // ---------------------------------------------------------------
  // adder shared by add, add with carry and subtract with borrow
  // ---------------------------------------------------------------
  logic       sub;
  logic       c0;
  logic [7:0] yy;
  logic [4:0] s_lo;
  logic [7:0] s_7;
  logic [8:0] s_full;
  logic [15:0] prod;
  logic [7:0] quo;
  logic [7:0] rem;
  logic       adj_lo;
  logic       adj_hi;
  logic [8:0] da1;
  logic [8:0] da2;

  // unsigned arithmetic; borrow is the inverted carry
  assign sub    = op == mat_pkg::OP_SUBB;
  assign c0     = sub ? ~cy_in : (op == mat_pkg::OP_ADDC) & cy_in;
  assign yy     = sub ? ~y : y;
  assign s_lo   = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, c0};
  assign s_7    = {1'b0, x[6:0]} + {1'b0, yy[6:0]} + {7'h00, c0};
  assign s_full = {1'b0, x} + {1'b0, yy} + {8'h00, c0};
  assign prod   = x * y;
  assign quo    = (y != 8'h00) ? x / y : x;
  assign rem    = (y != 8'h00) ? x % y : y;
  assign adj_lo = (x[3:0] > mat_pkg::BCD_MAX) | ac_in;
  assign da1    = {1'b0, x} + (adj_lo ? mat_pkg::DA_LO_ADJ : 9'h000);
  assign adj_hi = (da1[7:4] > mat_pkg::BCD_MAX) | cy_in | da1[8];
  assign da2    = da1 + (adj_hi ? mat_pkg::DA_HI_ADJ : 9'h000);

  // ---------------------------------------------------------------
  // operation select
  // ---------------------------------------------------------------
  always_comb begin
    r     = '0;
    r.res = x;
    case (op)
      mat_pkg::OP_ADD, mat_pkg::OP_ADDC, mat_pkg::OP_SUBB: begin
        r.res   = s_full[7:0];
        r.cy    = s_full[8] ^ sub;
        r.ac    = s_lo[4] ^ sub;
        r.ov    = s_full[8] ^ s_7[7];
        r.wr_cy = 1'b1;
        r.wr_ac = 1'b1;
        r.wr_ov = 1'b1;
      end
      mat_pkg::OP_AND: r.res = x & y;
      mat_pkg::OP_OR:  r.res = x | y;
      mat_pkg::OP_XOR: r.res = x ^ y;
      mat_pkg::OP_CPL: r.res = ~x;
      mat_pkg::OP_INC: r.res = x + 8'h01;
      mat_pkg::OP_DEC: r.res = x - 8'h01;
      mat_pkg::OP_CLR: r.res = 8'h00;
      mat_pkg::OP_RL:  r.res = {x[6:0], x[7]};
      mat_pkg::OP_RR:  r.res = {x[0], x[7:1]};
      mat_pkg::OP_RLC: begin
        r.res   = {x[6:0], cy_in};
        r.cy    = x[7];
        r.wr_cy = 1'b1;
      end
      mat_pkg::OP_RRC: begin
        r.res   = {cy_in, x[7:1]};
        r.cy    = x[0];
        r.wr_cy = 1'b1;
      end
      mat_pkg::OP_SWAP: r.res = {x[3:0], x[7:4]};
      mat_pkg::OP_DA: begin
        r.res   = da2[7:0];
        r.cy    = cy_in | da1[8] | da2[8];
        r.wr_cy = 1'b1;
      end
      mat_pkg::OP_MUL: begin
        r.res    = prod[7:0];
        r.res_hi = prod[15:8];
        r.ov     = prod[15:8] != 8'h00;
        r.wr_cy  = 1'b1;
        r.wr_ov  = 1'b1;
        r.wr_hi  = 1'b1;
      end
      mat_pkg::OP_DIV: begin
        // divide by zero leaves both operands untouched and sets overflow
        r.res    = quo;
        r.res_hi = rem;
        r.ov     = y == 8'h00;
        r.wr_cy  = 1'b1;
        r.wr_ov  = 1'b1;
        r.wr_hi  = y != 8'h00;
      end
      default: r.res = x;
    endcase
  end

endmodule

// ===== hw/mat_core.sv
`timescale 1ns/1ps

// Behaviour
// - one machine cycle per clock; every cycle count is a clock count
// - opcodes use legacy encoding and legacy function
// - next opcode fetch overlaps current execution; no dummy fetches
// - arithmetic treats all 8-bit operands as unsigned
// - rotate, swap, clear, complement, decimal adjust act on main result only
// - operands from main result, second operand or memory; result out
// - carry, overflow and parity live in the memory-mapped flags word
// - add: register 1 cycle, direct, indirect, immediate 2 cycles
// - add with carry: register 1 cycle, other forms 2 cycles
// - subtract with borrow: register 1 cycle, other forms 2 cycles
// - inc/dec: main result 1, register 2, memory 3, pointer inc 1
// - multiply and divide with second operand, one byte, 5 cycles
// - clear, complement, rotates, swap, decimal adjust finish in 1 cycle
// - and: register 1, memory forms 2, to direct 3, immediate to direct 4
// - or: register 1, memory forms 2, to direct 3, immediate to direct 4
// - xor: register 1, memory forms 2, to direct 3, immediate to direct 4
// - unit offers and, or, xor, not, add, add with carry, subtract
// - most one-byte instructions complete in a single cycle
module mat_core #(
  parameter logic [15:0] RESET_PC = mat_pkg::RST_PC
) (
  // clock and control
  input  logic        CLK,
  input  logic        RESET,
  input  logic        CE,
  // code memory, combinational read
  output logic [15:0] CODE_ADDR,
  output logic        CODE_RD,
  input  logic [7:0]  CODE_DATA,
  // data memory, combinational read
  output logic [7:0]  DATA_ADDR,
  output logic        DATA_RD,
  output logic        DATA_WR,
  output logic [7:0]  DATA_WDATA,
  input  logic [7:0]  DATA_RDATA,
  // architectural state
  output logic [7:0]  MAIN_RESULT,
  output logic [7:0]  OPERAND_B,
  output logic [7:0]  STATUS_FLAGS,
  output logic [15:0] POINTER16,
  // status
  output logic [7:0]  ALU_OUT,
  output logic        INSTR_DONE,
  output logic        UNSUPPORTED
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic mat_pkg::mat_dec_t decode(input logic [7:0] op);
    mat_pkg::mat_dec_t  d;
    mat_pkg::mat_mode_t m;
    logic [3:0]         hi;
    logic [3:0]         lo;
    logic               lgc;
    logic               incdec;
    hi     = op[7:4];
    lo     = op[3:0];
    lgc    = hi == mat_pkg::GRP_ORL || hi == mat_pkg::GRP_ANL ||
             hi == mat_pkg::GRP_XRL;
    incdec = hi == mat_pkg::GRP_INC || hi == mat_pkg::GRP_DEC;
    if (lo[3])
      m = mat_pkg::M_REG;
    else if (lo[3:1] == 3'b011)
      m = mat_pkg::M_IND;
    else if (lo == mat_pkg::LO_DIR)
      m = mat_pkg::M_DIR;
    else if (lo == mat_pkg::LO_IMM)
      m = mat_pkg::M_IMM;
    else
      m = mat_pkg::M_NONE;
    d.kind    = mat_pkg::K_NONE;
    d.mode    = m;
    d.mem_imm = 1'b0;
    d.ncyc    = mat_pkg::CYC_SHORT;
    d.nbytes  = (m == mat_pkg::M_DIR || m == mat_pkg::M_IMM) ?
                mat_pkg::BYTES_TWO : mat_pkg::BYTES_ONE;
    case (hi)
      mat_pkg::GRP_ADD:  d.aop = mat_pkg::OP_ADD;
      mat_pkg::GRP_ADDC: d.aop = mat_pkg::OP_ADDC;
      mat_pkg::GRP_SUBB: d.aop = mat_pkg::OP_SUBB;
      mat_pkg::GRP_ORL:  d.aop = mat_pkg::OP_OR;
      mat_pkg::GRP_ANL:  d.aop = mat_pkg::OP_AND;
      mat_pkg::GRP_XRL:  d.aop = mat_pkg::OP_XOR;
      mat_pkg::GRP_INC:  d.aop = mat_pkg::OP_INC;
      mat_pkg::GRP_DEC:  d.aop = mat_pkg::OP_DEC;
      default:           d.aop = mat_pkg::OP_PASS;
    endcase
    if (d.aop != mat_pkg::OP_PASS && !incdec && m != mat_pkg::M_NONE) begin
      d.kind = mat_pkg::K_ACC;
      d.ncyc = (m == mat_pkg::M_REG) ?
               mat_pkg::CYC_SHORT : mat_pkg::CYC_MEM_OPND;
    end else if (lgc && lo == mat_pkg::LO_MEM_A) begin
      d.kind   = mat_pkg::K_MEM;
      d.mode   = mat_pkg::M_DIR;
      d.nbytes = mat_pkg::BYTES_TWO;
      d.ncyc   = mat_pkg::CYC_RMW;
    end else if (lgc && lo == mat_pkg::LO_MEM_IMM) begin
      d.kind    = mat_pkg::K_MEM;
      d.mode    = mat_pkg::M_DIR;
      d.mem_imm = 1'b1;
      d.nbytes  = mat_pkg::BYTES_THREE;
      d.ncyc    = mat_pkg::CYC_RMW_IMM;
    end else if (incdec && m == mat_pkg::M_IMM) begin
      d.kind   = mat_pkg::K_UNARY;
      d.mode   = mat_pkg::M_NONE;
      d.nbytes = mat_pkg::BYTES_ONE;
    end else if (incdec && m != mat_pkg::M_NONE) begin
      d.kind = mat_pkg::K_MEM;
      d.ncyc = (m == mat_pkg::M_REG) ?
               mat_pkg::CYC_INC_REG : mat_pkg::CYC_RMW;
    end else begin
      d.mode   = mat_pkg::M_NONE;
      d.nbytes = mat_pkg::BYTES_ONE;
      d.aop    = mat_pkg::OP_PASS;
      case (op)
        mat_pkg::OPC_NOP:  d.kind = mat_pkg::K_NOP;
        mat_pkg::OPC_PINC: d.kind = mat_pkg::K_PTRINC;
        mat_pkg::OPC_CLR:  d.aop  = mat_pkg::OP_CLR;
        mat_pkg::OPC_CPL:  d.aop  = mat_pkg::OP_CPL;
        mat_pkg::OPC_RL:   d.aop  = mat_pkg::OP_RL;
        mat_pkg::OPC_RLC:  d.aop  = mat_pkg::OP_RLC;
        mat_pkg::OPC_RR:   d.aop  = mat_pkg::OP_RR;
        mat_pkg::OPC_RRC:  d.aop  = mat_pkg::OP_RRC;
        mat_pkg::OPC_SWAP: d.aop  = mat_pkg::OP_SWAP;
        mat_pkg::OPC_DA:   d.aop  = mat_pkg::OP_DA;
        mat_pkg::OPC_MUL:  d.aop  = mat_pkg::OP_MUL;
        mat_pkg::OPC_DIV:  d.aop  = mat_pkg::OP_DIV;
        default:           d.kind = mat_pkg::K_NONE;
      endcase
      if (op == mat_pkg::OPC_MUL || op == mat_pkg::OPC_DIV) begin
        d.kind = mat_pkg::K_MULDIV;
        d.ncyc = mat_pkg::CYC_MULDIV;
      end else if (d.aop != mat_pkg::OP_PASS)
        d.kind = mat_pkg::K_UNARY;
    end
    return d;
  endfunction

  // special function registers held inside the core
  function automatic mat_pkg::mat_sfr_t sfr_sel(input logic [7:0] adr);
    case (adr)
      mat_pkg::SFR_MAIN_RESULT: return mat_pkg::SEL_A;
      mat_pkg::SFR_OPERAND_B:   return mat_pkg::SEL_B;
      mat_pkg::SFR_STATUS:      return mat_pkg::SEL_PSW;
      mat_pkg::SFR_PTR_LO:      return mat_pkg::SEL_PLO;
      mat_pkg::SFR_PTR_HI:      return mat_pkg::SEL_PHI;
      default:                  return mat_pkg::SEL_NONE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  a_reg, a_next;
  logic [7:0]  b_reg, b_next;
  logic [7:0]  st_reg, st_next;
  logic [15:0] ptr_reg, ptr_next;
  logic [15:0] pc_reg;
  logic [2:0]  cnt_reg;
  logic [7:0]  opc_reg;
  logic [7:0]  tmp_reg;
  logic [7:0]  ea_reg;
  logic [7:0]  ri_reg;
  logic [7:0]  imm_reg;
  logic [7:0]  out_reg;

  mat_pkg::mat_dec_t     dec;
  mat_pkg::mat_alu_res_t alu;
  mat_pkg::mat_sfr_t     rd_sel;
  mat_pkg::mat_sfr_t     wr_sel;
  logic [7:0]  cur_op;
  logic        last;
  logic        fetch;
  logic [1:0]  bank;
  logic [7:0]  rn_addr;
  logic [7:0]  ri_addr;
  logic        uses_mem;
  logic [2:0]  rd_cyc;
  logic        ptr_phase;
  logic        rd_phase;
  logic        wr_phase;
  logic [7:0]  ea_now;
  logic [7:0]  flags;
  logic [7:0]  local_val;
  logic [7:0]  rd_val;
  logic [7:0]  mem_val;
  logic [7:0]  alu_x;
  logic [7:0]  alu_y;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  // the opcode is live on the code bus in the first cycle only
  assign cur_op = (cnt_reg == 3'h0) ? CODE_DATA : opc_reg;
  assign dec    = decode(cur_op);
  assign last   = cnt_reg == (dec.ncyc - 3'h1);
  assign fetch  = cnt_reg < {1'b0, dec.nbytes};

  // ---------------------------------------------------------------
  // operand addressing
  // ---------------------------------------------------------------
  assign bank     = st_reg[mat_pkg::BANK_LO +: 2];
  assign rn_addr  = {3'b000, bank, cur_op[2:0]};
  assign ri_addr  = {3'b000, bank, 2'b00, cur_op[0]};
  assign uses_mem = (dec.kind == mat_pkg::K_ACC ||
                     dec.kind == mat_pkg::K_MEM) &&
                    dec.mode != mat_pkg::M_IMM;
  assign rd_cyc   = (dec.mode == mat_pkg::M_REG) ? 3'h0 : 3'h1;
  assign ptr_phase = uses_mem && dec.mode == mat_pkg::M_IND &&
                     cnt_reg == 3'h0;
  assign rd_phase  = uses_mem && cnt_reg == rd_cyc;
  assign wr_phase  = dec.kind == mat_pkg::K_MEM && last;
  assign ea_now = (dec.mode == mat_pkg::M_REG) ? rn_addr :
                  (dec.mode == mat_pkg::M_IND) ? ri_reg : CODE_DATA;

  // direct addresses of core registers stay inside the core
  assign rd_sel = (dec.mode == mat_pkg::M_DIR) ? sfr_sel(ea_now) :
                  mat_pkg::SEL_NONE;
  assign wr_sel = (dec.mode == mat_pkg::M_DIR) ? sfr_sel(ea_reg) :
                  mat_pkg::SEL_NONE;
  assign flags  = {st_reg[7:1], ^a_reg};
  assign local_val = (rd_sel == mat_pkg::SEL_A)   ? a_reg :
                     (rd_sel == mat_pkg::SEL_B)   ? b_reg :
                     (rd_sel == mat_pkg::SEL_PSW) ? flags :
                     (rd_sel == mat_pkg::SEL_PLO) ? ptr_reg[7:0] :
                     ptr_reg[15:8];
  assign rd_val  = (rd_sel == mat_pkg::SEL_NONE) ? DATA_RDATA : local_val;
  assign mem_val = rd_phase ? rd_val : tmp_reg;

  // ---------------------------------------------------------------
  // arithmetic unit
  // ---------------------------------------------------------------
  assign alu_x = (dec.kind == mat_pkg::K_MEM) ? mem_val : a_reg;
  assign alu_y = (dec.kind == mat_pkg::K_MEM) ?
                   (dec.mem_imm ? imm_reg : a_reg) :
                 (dec.kind == mat_pkg::K_MULDIV) ? b_reg :
                 (dec.mode == mat_pkg::M_IMM) ? CODE_DATA : mem_val;

  mat_alu u_alu (
    .op    (dec.aop),
    .x     (alu_x),
    .y     (alu_y),
    .cy_in (st_reg[mat_pkg::FLAG_CY]),
    .ac_in (st_reg[mat_pkg::FLAG_AC]),
    .r     (alu)
  );

  // ---------------------------------------------------------------
  // architectural next state
  // ---------------------------------------------------------------
  always_comb begin
    a_next   = a_reg;
    b_next   = b_reg;
    st_next  = st_reg;
    ptr_next = ptr_reg;
    if (last) begin
      case (dec.kind)
        mat_pkg::K_ACC, mat_pkg::K_UNARY: a_next = alu.res;
        mat_pkg::K_MULDIV: begin
          a_next = alu.res;
          if (alu.wr_hi)
            b_next = alu.res_hi;
        end
        mat_pkg::K_PTRINC: ptr_next = ptr_reg + 16'h0001;
        mat_pkg::K_MEM: begin
          case (wr_sel)
            mat_pkg::SEL_A:   a_next = alu.res;
            mat_pkg::SEL_B:   b_next = alu.res;
            mat_pkg::SEL_PSW: st_next = alu.res;
            mat_pkg::SEL_PLO: ptr_next[7:0] = alu.res;
            mat_pkg::SEL_PHI: ptr_next[15:8] = alu.res;
            default:          st_next = st_reg;
          endcase
        end
        default: a_next = a_reg;
      endcase
      if (alu.wr_cy)
        st_next[mat_pkg::FLAG_CY] = alu.cy;
      if (alu.wr_ac)
        st_next[mat_pkg::FLAG_AC] = alu.ac;
      if (alu.wr_ov)
        st_next[mat_pkg::FLAG_OV] = alu.ov;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt_reg <= 3'h0;
      pc_reg  <= RESET_PC;
      opc_reg <= mat_pkg::RST_BYTE;
    end else if (CE) begin
      cnt_reg <= last ? 3'h0 : cnt_reg + 3'h1;
      pc_reg  <= fetch ? pc_reg + 16'h0001 : pc_reg;
      if (cnt_reg == 3'h0)
        opc_reg <= CODE_DATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ri_reg  <= mat_pkg::RST_BYTE;
      tmp_reg <= mat_pkg::RST_BYTE;
      ea_reg  <= mat_pkg::RST_BYTE;
      imm_reg <= mat_pkg::RST_BYTE;
    end else if (CE) begin
      if (ptr_phase)
        ri_reg <= DATA_RDATA;
      if (rd_phase) begin
        tmp_reg <= rd_val;
        ea_reg  <= ea_now;
      end
      if (cnt_reg == 3'h2)
        imm_reg <= CODE_DATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      a_reg   <= mat_pkg::RST_BYTE;
      b_reg   <= mat_pkg::RST_BYTE;
      st_reg  <= mat_pkg::RST_BYTE;
      ptr_reg <= mat_pkg::RST_PTR;
      out_reg <= mat_pkg::RST_BYTE;
    end else if (CE) begin
      a_reg   <= a_next;
      b_reg   <= b_next;
      st_reg  <= st_next;
      ptr_reg <= ptr_next;
      if (last)
        out_reg <= alu.res;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign CODE_ADDR    = pc_reg;
  assign CODE_RD      = CE & fetch & ~RESET;
  assign DATA_ADDR    = wr_phase ? ea_reg : ptr_phase ? ri_addr : ea_now;
  assign DATA_RD      = CE & ~RESET & (ptr_phase |
                        (rd_phase & rd_sel == mat_pkg::SEL_NONE));
  assign DATA_WR      = CE & ~RESET & wr_phase &
                        (wr_sel == mat_pkg::SEL_NONE);
  assign DATA_WDATA   = alu.res;
  assign MAIN_RESULT  = a_reg;
  assign OPERAND_B    = b_reg;
  assign STATUS_FLAGS = flags;
  assign POINTER16    = ptr_reg;
  assign ALU_OUT      = out_reg;
  assign INSTR_DONE   = CE & ~RESET & last;
  assign UNSUPPORTED  = CE & ~RESET & (dec.kind == mat_pkg::K_NONE);

endmodule

// ===== test/mat_monitor.sv
`timescale 1ns/1ps
module mat_monitor #(
  parameter logic [15:0] RESET_PC = 16'h0000
) (
  // clock and control
  input logic        CLK,
  input logic        RESET,
  input logic        CE,
  // code bus
  input logic [15:0] CODE_ADDR,
  input logic        CODE_RD,
  input logic [7:0]  CODE_DATA,
  // state and status
  input logic        DATA_WR,
  input logic [7:0]  MAIN_RESULT,
  input logic [7:0]  STATUS_FLAGS,
  input logic        INSTR_DONE
);
  logic start_reg;
  logic first;
  // marks cycle 0 of each instruction, where CODE_DATA is an opcode
  always_ff @(posedge CLK)
    if (RESET) start_reg <= 1'b1;
    else if (CE) start_reg <= INSTR_DONE;
  // opcode cycle of a running core, judged on sampled values only
  assign first = start_reg && CE && !RESET;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET || !CE);
  AST_RESET_PC: assert property (disable iff (1'b0)
    RESET |=> CODE_ADDR == RESET_PC) else $error("bad reset address");
  AST_PARITY: assert property (STATUS_FLAGS[0] == ^MAIN_RESULT)
    else $error("parity wrong");
  AST_FETCH_STEP: assert property (CODE_RD |=>
    CODE_ADDR == $past(CODE_ADDR) + 16'h0001) else $error("bad step");
  AST_NO_DUMMY: assert property (CE && !RESET && !CODE_RD |=>
    $stable(CODE_ADDR)) else $error("dummy fetch");
  AST_OVERLAP: assert property (first |-> CODE_RD)
    else $error("opcode not fetched");
  AST_ONE_CYC: assert property (first && CODE_DATA inside
    {[8'h28:8'h2F], 8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4,
    8'hD4, 8'h04, 8'h14, 8'hA3} |-> INSTR_DONE) else $error("not 1");
  AST_TWO_CYC: assert property (first && CODE_DATA inside
    {8'h24, 8'h34, 8'h94, 8'h54, 8'h44, 8'h64, 8'h65}
    |-> !INSTR_DONE ##1 INSTR_DONE) else $error("not 2 cycles");
  AST_MULDIV: assert property (first &&
    CODE_DATA inside {8'hA4, 8'h84} |-> !INSTR_DONE ##1
    !INSTR_DONE [*3] ##1 INSTR_DONE) else $error("not 5 cycles");
  AST_CLR: assert property (first && CODE_DATA == 8'hE4
    |=> MAIN_RESULT == 8'h00) else $error("clear failed");
  AST_WR_LAST: assert property (DATA_WR |-> INSTR_DONE)
    else $error("write not last");
  cover property (start_reg && CODE_DATA == 8'hA4);
  cover property (start_reg && CODE_DATA == 8'hD4);
  cover property (DATA_WR);
endmodule
bind mat_core mat_monitor #(.RESET_PC(RESET_PC)) mon (.CLK, .RESET,
  .CE, .CODE_ADDR, .CODE_RD, .CODE_DATA, .DATA_WR, .MAIN_RESULT,
  .STATUS_FLAGS, .INSTR_DONE);

// ===== test/mat_mem.sv
`timescale 1ns/1ps
module mat_mem (
  // clock
  input logic        clk,
  // code side
  input logic [15:0] code_addr,
  output logic [7:0] code_data,
  // data side
  input logic [7:0]  data_addr,
  input logic        data_rd,
  input logic        data_wr,
  input logic [7:0]  data_wdata,
  output logic [7:0] data_rdata
);
  logic [7:0] code [256];
  logic [7:0] ram [256];
  assign code_data = code[code_addr[7:0]];
  // unselected bus shows inverted contents, never stale data
  assign data_rdata = data_rd ? ram[data_addr] : ~ram[data_addr];
  always @(posedge clk)
    if (data_wr) ram[data_addr] <= data_wdata;
endmodule

// ===== test/mcu_alu_exec_timing_bench.sv
`timescale 1ns/1ps
module mcu_alu_exec_timing_bench;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, code_rd, rd, wr, done, uns;
  logic [15:0] code_addr, ptr;
  logic [7:0] code_data, daddr, wdata, rdata, acc, opb, flags, aout;
  int miscompares = 0, checks_done = 0;
  mat_core DUT (.CLK(clk), .RESET(reset), .CE(ce), .CODE_ADDR(code_addr),
    .CODE_RD(code_rd), .CODE_DATA(code_data), .DATA_ADDR(daddr),
    .DATA_RD(rd), .DATA_WR(wr), .DATA_WDATA(wdata), .DATA_RDATA(rdata),
    .MAIN_RESULT(acc), .OPERAND_B(opb), .STATUS_FLAGS(flags),
    .POINTER16(ptr), .ALU_OUT(aout), .INSTR_DONE(done), .UNSUPPORTED(uns));
  mat_mem mem (.clk(clk), .code_addr(code_addr), .code_data(code_data),
    .data_addr(daddr), .data_rd(rd), .data_wr(wr), .data_wdata(wdata),
    .data_rdata(rdata));
  initial forever #5 clk = ~clk;
  // ----------
  // helpers
  // ----------
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    checks_done++;
    if (s !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, s);
      miscompares++;
    end
  endtask
  // loads a program under reset, runs n instructions, counts cycles
  task automatic run(input logic [7:0] p[$], input int n, output int c);
    @(posedge clk) reset <= 1'b1;
    // load away from the edge so the core never races the new code
    @(negedge clk);
    foreach (mem.code[i]) mem.code[i] = (i < p.size()) ? p[i] : 8'h00;
    @(posedge clk) reset <= 1'b0;
    c = 0;
    while (n > 0) begin
      @(negedge clk);
      c++;
      if (done === 1'b1) n--;
      if (c > 200) begin
        miscompares++;
        print_verdict();
      end
    end
    @(negedge clk);
  endtask
  task automatic t_unary();
    int c;
    run('{8'hE4, 8'h04, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hF4,
      8'h14, 8'hD4, 8'hA3}, 11, c);
    chk("cycles", 16'd11, 16'(c));
    chk("acc", 8'h54, acc);
    chk("carry", 1'b1, flags[7]);
    chk("ptr", 16'h0001, ptr);
  endtask
  task automatic t_arith();
    int c;
    run('{8'hE4, 8'h24, 8'h35, 8'h94, 8'h36, 8'h34, 8'h00}, 4, c);
    chk("cycles", 16'd7, 16'(c));
    chk("acc", 8'h00, acc);
    chk("carry", 1'b1, flags[7]);
  endtask
  task automatic t_muldiv();
    int c;
    run('{8'hE4, 8'h24, 8'h0C, 8'h43, 8'hF0, 8'h0A, 8'hA4, 8'h43,
      8'hF0, 8'h05, 8'h84}, 6, c);
    chk("cycles", 16'd21, 16'(c));
    chk("acc", 8'h18, acc);
    chk("alu out", 8'h18, aout);
    chk("opb", 8'h00, opb);
  endtask
  task automatic t_mem();
    int c;
    mem.ram[8'h40] = 8'h3E;
    mem.ram[8'h00] = 8'h40;
    run('{8'h05, 8'h40, 8'h53, 8'h40, 8'h0F, 8'h65, 8'h40, 8'h26, 8'h08,
      8'h28}, 6, c);
    chk("cycles", 16'd14, 16'(c));
    chk("ram", 8'h0F, mem.ram[8'h40]);
    chk("r0", 8'h41, mem.ram[8'h00]);
    chk("acc", 8'h5F, acc);
  endtask
  task automatic t_freeze();
    int c;
    run('{8'h04, 8'h04, 8'h04, 8'hC3}, 2, c);
    @(posedge clk) ce <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("held acc", 8'h03, acc);
    chk("held pc", 16'h0003, code_addr);
    chk("held done", 1'b0, done);
    @(posedge clk) ce <= 1'b1;
    @(negedge clk);
    chk("unsupported", 1'b1, uns);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    t_unary();
    t_arith();
    t_muldiv();
    t_mem();
    t_freeze();
    print_verdict();
  end
endmodule
